/* hdl/vpr_pkg.sv */
// Shared widths, fill values, opcodes and instruction classes.
// Assumes one core clock; users refer to names as vpr_pkg::name.
package vpr_pkg;
	localparam int BYTE_W = 8;
	localparam int EW = 32;
	localparam int NE = 8;
	localparam int VW = EW * NE;
	localparam int PB = EW / BYTE_W;
	localparam int PW = NE * PB;
	localparam int IW = $clog2(NE);
	localparam int RW = 5;
	localparam int PRW = 4;
	localparam int SW = 2;
	localparam int SRC_N = 2;
	localparam int UNIT_BYTE = 1;
	localparam int UNIT_HALF = 2;
	localparam int UNIT_WORD = 4;
	localparam int FP_EXP_W = 8;
	localparam int FP_FRAC_W = 23;
	localparam int FP_GRD = 3;
	localparam int FP_MW = FP_FRAC_W + FP_GRD + 2;
	localparam int FP_EXP_MAX = 255;
	localparam logic [FP_EXP_W-1:0] FP_EXP_ONES = 8'hff;
	localparam logic [EW-1:0] FP_POS_ZERO = 32'h0000_0000;
	localparam logic [EW-1:0] FP_POS_INF = 32'h7f80_0000;
	localparam logic [EW-1:0] FP_NEG_INF = 32'hff80_0000;
	localparam logic [EW-1:0] FP_DEF_NAN = 32'h7fc0_0000;
	localparam logic [EW-1:0] INT_ZERO = 32'h0000_0000;
	localparam logic [EW-1:0] INT_ONES = 32'hffff_ffff;
	localparam logic [EW-1:0] INT_SMIN = 32'h8000_0000;
	localparam logic [EW-1:0] INT_SMAX = 32'h7fff_ffff;

	typedef enum logic [5:0] {
		OP_COND_EXTRACT_AFTER_LAST = 6'h00, OP_COND_EXTRACT_LAST = 6'h01,
		OP_EXTRACT_AFTER_LAST = 6'h02, OP_EXTRACT_LAST = 6'h03,
		OP_ACTIVE_PACK = 6'h04, OP_TABLE_LOOKUP_PERMUTE = 6'h05,
		OP_REVERSE_ELEMENTS = 6'h06, OP_REVERSE_BYTES_IN_ELEM = 6'h07,
		OP_REVERSE_HALVES_IN_ELEM = 6'h08, OP_REVERSE_WORDS_IN_ELEM = 6'h09,
		OP_INTERLEAVE_EVEN = 6'h0a, OP_INTERLEAVE_ODD = 6'h0b,
		OP_CONCAT_EVEN = 6'h0c, OP_CONCAT_ODD = 6'h0d,
		OP_INTERLEAVE_LOW_HALVES = 6'h0e, OP_INTERLEAVE_HIGH_HALVES = 6'h0f,
		OP_PAIR_WINDOW_EXTRACT = 6'h10, OP_SHIFT_INSERT_SCALAR = 6'h11,
		OP_BROADCAST_ELEMENT = 6'h12, OP_SIGNED_WIDEN_LOW = 6'h13,
		OP_SIGNED_WIDEN_HIGH = 6'h14, OP_ZERO_WIDEN_LOW = 6'h15,
		OP_ZERO_WIDEN_HIGH = 6'h16, OP_INDEX_GEN = 6'h17,
		OP_MOVE_PREFIX = 6'h18, OP_FP_ORDERED_SUM = 6'h20,
		OP_FP_TREE_SUM = 6'h21, OP_FP_TREE_MAX = 6'h22,
		OP_FP_TREE_MIN = 6'h23, OP_FP_TREE_NUM_MAX = 6'h24,
		OP_FP_TREE_NUM_MIN = 6'h25, OP_AND_REDUCE = 6'h26,
		OP_XOR_REDUCE = 6'h27, OP_OR_REDUCE = 6'h28,
		OP_SIGNED_SUM_REDUCE = 6'h29, OP_UNSIGNED_SUM_REDUCE = 6'h2a,
		OP_SIGNED_MAX_REDUCE = 6'h2b, OP_SIGNED_MIN_REDUCE = 6'h2c,
		OP_UNSIGNED_MAX_REDUCE = 6'h2d, OP_UNSIGNED_MIN_REDUCE = 6'h2e
	} vpr_op_t;

	typedef enum logic [2:0] {
		CLS_OTHER = 3'h0,
		CLS_PREFIX_CAPABLE = 3'h1,
		CLS_HALT = 3'h2,
		CLS_BREAKPOINT = 3'h3,
		CLS_MOVE_PREFIX = 3'h4
	} vpr_cls_t;
endpackage

/* hdl/vpr_link_if.sv */
// Link between the instruction issue end and the permute/reduce datapath.
// Assumes both ends run on the same core clock.
`timescale 1ns/1ns
interface vpr_link_if;
	logic reqValid;
	vpr_pkg::vpr_op_t reqOp;
	logic reqPredMode;
	logic reqPredicated;
	logic reqPairBad;
	logic [vpr_pkg::VW-1:0] vecA;
	logic [vpr_pkg::VW-1:0] vecB;
	logic [vpr_pkg::PW-1:0] govPred;
	logic [vpr_pkg::PW-1:0] predA;
	logic [vpr_pkg::PW-1:0] predB;
	logic [vpr_pkg::EW-1:0] scalar;
	logic [vpr_pkg::EW-1:0] idxStart;
	logic [vpr_pkg::EW-1:0] idxStep;
	logic [vpr_pkg::IW-1:0] elemIdx;
	logic resValid;
	logic resUndef;
	logic [vpr_pkg::VW-1:0] resVec;
	logic [vpr_pkg::PW-1:0] resPred;
	logic [vpr_pkg::EW-1:0] resScalar;

	modport dev (
		input reqValid, reqOp, reqPredMode, reqPredicated, reqPairBad,
		input vecA, vecB, govPred, predA, predB, scalar, idxStart, idxStep, elemIdx,
		output resValid, resUndef, resVec, resPred, resScalar
	);
	modport iss (
		output reqValid, reqOp, reqPredMode, reqPredicated, reqPairBad,
		output vecA, vecB, govPred, predA, predB, scalar, idxStart, idxStep, elemIdx,
		input resValid, resUndef, resVec, resPred, resScalar
	);
endinterface

/* hdl/vpr_unit.sv */
// Permute, unpack, index and horizontal reduction datapath, one op per cycle.
// Assumes the issue end drives the link from flops on core_clk.
`timescale 1ns/1ns
// Notes on behaviour
// - Conditional last or after-last extract, three destinations
// - Unconditional last or after-last extract to scalar
// - Pack active elements low, zero the rest
// - Table lookup picks source element by index
// - Reverse elements, or bytes/halves/words within elements
// - Even/odd interleave, even/odd concat, half zips
// - Window of vector length from vector pair
// - Shift up one element, insert scalar lowest
// - Broadcast one indexed element everywhere
// - Widen low or high half, sign or zero
// - Predicate permutes move whole predicate elements
// - Index vector: start plus step per element
// - Prefix follower: capable, halt or breakpoint only
// - Follower reuses prefix destination, no aliasing source
// - Predicated prefix: same predicate and element size
// - Predicated prefix never before unpredicated instruction
// - Bad pairing may trap, skip or corrupt
// - Ordered FP sum from scalar, increasing order
// - Other FP reductions use pairwise tree
// - Integer reductions any order, neutral fills
// - Max/min integer reductions use extreme fills
// - FP tree fills: zero, infinities, default NaN
module vpr_unit (
	input wire logic core_clk,
	input wire logic rst,
	vpr_link_if.dev lnk,
	output logic [vpr_pkg::IW:0] activeCount
);
	localparam int EW = vpr_pkg::EW;
	localparam int NE = vpr_pkg::NE;
	localparam int VW = vpr_pkg::VW;
	localparam int PB = vpr_pkg::PB;
	localparam int PW = vpr_pkg::PW;
	localparam int IW = vpr_pkg::IW;
	localparam int BW = vpr_pkg::BYTE_W;
	localparam int MW = vpr_pkg::FP_MW;
	localparam int XW = vpr_pkg::FP_EXP_W;
	localparam int FW = vpr_pkg::FP_FRAC_W;
	localparam logic signed [XW+1:0] E_ONE = 10'sh001;

	function automatic logic [XW-1:0] expOf(input logic [EW-1:0] x);
		return x[EW-2 -: XW];
	endfunction

	function automatic logic isNan(input logic [EW-1:0] x);
		return expOf(x) == vpr_pkg::FP_EXP_ONES && x[FW-1:0] != '0;
	endfunction

	// Truncating add, subnormals flushed: cheap, not IEEE rounding
	function automatic logic [EW-1:0] fpAdd(input logic [EW-1:0] x, input logic [EW-1:0] y);
		logic [EW-1:0] a;
		logic [EW-1:0] b;
		logic [MW-1:0] ma;
		logic [MW-1:0] mb;
		logic signed [XW+1:0] e;
		int d;
		a = x;
		b = y;
		if (expOf(x) == vpr_pkg::FP_EXP_ONES) return x;
		if (expOf(y) == vpr_pkg::FP_EXP_ONES) return y;
		if (y[EW-2:0] > x[EW-2:0]) begin
			a = y;
			b = x;
		end
		if (expOf(b) == '0) return a;
		e = $signed({2'b00, expOf(a)});
		d = int'(expOf(a)) - int'(expOf(b));
		ma = {2'b01, a[FW-1:0], {vpr_pkg::FP_GRD{1'b0}}};
		mb = {2'b01, b[FW-1:0], {vpr_pkg::FP_GRD{1'b0}}} >> d;
		if (a[EW-1] == b[EW-1]) ma = ma + mb;
		else ma = ma - mb;
		if (ma == '0) return vpr_pkg::FP_POS_ZERO;
		if (ma[MW-1]) begin
			ma = ma >> 1;
			e = e + E_ONE;
		end
		for (int k = 0; k < MW; k++) begin
			if (!ma[MW-2]) begin
				ma = ma << 1;
				e = e - E_ONE;
			end
		end
		if (e <= 0) return {a[EW-1], {(EW-1){1'b0}}};
		if (e >= vpr_pkg::FP_EXP_MAX) return {a[EW-1], vpr_pkg::FP_POS_INF[EW-2:0]};
		return {a[EW-1], e[XW-1:0], ma[MW-3 -: FW]};
	endfunction

	function automatic logic fpLess(input logic [EW-1:0] a, input logic [EW-1:0] b);
		if (a[EW-1] != b[EW-1]) return a[EW-1] && (a[EW-2:0] | b[EW-2:0]) != '0;
		return a[EW-1] ? a[EW-2:0] > b[EW-2:0] : a[EW-2:0] < b[EW-2:0];
	endfunction

	function automatic logic [EW-1:0] fpPick(input logic isMax, input logic [EW-1:0] a, input logic [EW-1:0] b);
		return (fpLess(a, b) == isMax) ? b : a;
	endfunction

	function automatic logic [EW-1:0] combine(input vpr_pkg::vpr_op_t op, input logic [EW-1:0] a,
		input logic [EW-1:0] b);
		case (op)
			vpr_pkg::OP_AND_REDUCE: return a & b;
			vpr_pkg::OP_XOR_REDUCE: return a ^ b;
			vpr_pkg::OP_OR_REDUCE: return a | b;
			vpr_pkg::OP_SIGNED_SUM_REDUCE, vpr_pkg::OP_UNSIGNED_SUM_REDUCE: return a + b;
			vpr_pkg::OP_SIGNED_MAX_REDUCE: return ($signed(a) < $signed(b)) ? b : a;
			vpr_pkg::OP_SIGNED_MIN_REDUCE: return ($signed(a) > $signed(b)) ? b : a;
			vpr_pkg::OP_UNSIGNED_MAX_REDUCE: return (a < b) ? b : a;
			vpr_pkg::OP_UNSIGNED_MIN_REDUCE: return (a > b) ? b : a;
			vpr_pkg::OP_FP_TREE_SUM: return fpAdd(a, b);
			vpr_pkg::OP_FP_TREE_MAX: return (isNan(a) || isNan(b)) ? vpr_pkg::FP_DEF_NAN : fpPick(1'b1, a, b);
			vpr_pkg::OP_FP_TREE_MIN: return (isNan(a) || isNan(b)) ? vpr_pkg::FP_DEF_NAN : fpPick(1'b0, a, b);
			vpr_pkg::OP_FP_TREE_NUM_MAX: return isNan(a) ? b : (isNan(b) ? a : fpPick(1'b1, a, b));
			vpr_pkg::OP_FP_TREE_NUM_MIN: return isNan(a) ? b : (isNan(b) ? a : fpPick(1'b0, a, b));
			default: return a;
		endcase
	endfunction

	function automatic logic [EW-1:0] fillVal(input vpr_pkg::vpr_op_t op);
		case (op)
			vpr_pkg::OP_AND_REDUCE: return vpr_pkg::INT_ONES;
			vpr_pkg::OP_SIGNED_MAX_REDUCE: return vpr_pkg::INT_SMIN;
			vpr_pkg::OP_SIGNED_MIN_REDUCE: return vpr_pkg::INT_SMAX;
			vpr_pkg::OP_UNSIGNED_MIN_REDUCE: return vpr_pkg::INT_ONES;
			vpr_pkg::OP_FP_TREE_MAX: return vpr_pkg::FP_NEG_INF;
			vpr_pkg::OP_FP_TREE_MIN: return vpr_pkg::FP_POS_INF;
			vpr_pkg::OP_FP_TREE_NUM_MAX, vpr_pkg::OP_FP_TREE_NUM_MIN: return vpr_pkg::FP_DEF_NAN;
			default: return vpr_pkg::INT_ZERO;
		endcase
	endfunction

	logic anyAct;
	logic [IW-1:0] lastPos;
	logic [IW:0] actCnt;
	logic [VW-1:0] srcA;
	logic [VW-1:0] srcB;
	logic [VW-1:0] rVec;
	logic [PW-1:0] rPred;
	logic [EW-1:0] rScalar;
	logic [EW-1:0] pickEl;
	logic [EW-1:0] tblIdx;
	logic [IW:0] packPos;
	logic [EW-1:0] tree [NE];
	logic isWiden;
	int unitB;
	int sel;
	int half;

	// Predicate elements ride in element lanes so data permutes serve both
	always_comb begin
		anyAct = 1'b0;
		lastPos = '1;
		actCnt = '0;
		srcA = lnk.vecA;
		srcB = lnk.vecB;
		for (int i = 0; i < NE; i++) begin
			if (lnk.govPred[i*PB]) begin
				anyAct = 1'b1;
				lastPos = IW'(i);
				actCnt = actCnt + 1'b1;
			end
			if (lnk.reqPredMode) begin
				srcA[i*EW +: EW] = EW'(lnk.predA[i*PB +: PB]);
				srcB[i*EW +: EW] = EW'(lnk.predB[i*PB +: PB]);
			end
		end
	end

	always_comb begin
		rVec = '0;
		rScalar = '0;
		rPred = '0;
		packPos = '0;
		tblIdx = '0;
		pickEl = '0;
		unitB = vpr_pkg::UNIT_BYTE;
		sel = 0;
		half = 0;
		isWiden = 1'b0;
		for (int i = 0; i < NE; i++) tree[i] = '0;
		case (lnk.reqOp)
			vpr_pkg::OP_COND_EXTRACT_AFTER_LAST, vpr_pkg::OP_COND_EXTRACT_LAST,
			vpr_pkg::OP_EXTRACT_AFTER_LAST, vpr_pkg::OP_EXTRACT_LAST: begin
				sel = (lnk.reqOp == vpr_pkg::OP_COND_EXTRACT_AFTER_LAST ||
					lnk.reqOp == vpr_pkg::OP_EXTRACT_AFTER_LAST) ? int'(IW'(lastPos + 1'b1)) : int'(lastPos);
				pickEl = srcA[sel*EW +: EW];
				rScalar = pickEl;
				rVec = {NE{pickEl}};
				if ((lnk.reqOp == vpr_pkg::OP_COND_EXTRACT_AFTER_LAST ||
					lnk.reqOp == vpr_pkg::OP_COND_EXTRACT_LAST) && !anyAct) begin
					rScalar = lnk.scalar;
					rVec = srcB;
				end
			end
			vpr_pkg::OP_ACTIVE_PACK: begin
				for (int i = 0; i < NE; i++) begin
					if (lnk.govPred[i*PB]) begin
						rVec[packPos*EW +: EW] = srcA[i*EW +: EW];
						packPos = packPos + 1'b1;
					end
				end
			end
			vpr_pkg::OP_TABLE_LOOKUP_PERMUTE: begin
				for (int i = 0; i < NE; i++) begin
					tblIdx = srcB[i*EW +: EW];
					if (tblIdx < NE) rVec[i*EW +: EW] = srcA[tblIdx[IW-1:0]*EW +: EW];
				end
			end
			vpr_pkg::OP_REVERSE_ELEMENTS: begin
				for (int i = 0; i < NE; i++) rVec[i*EW +: EW] = srcA[(NE-1-i)*EW +: EW];
			end
			vpr_pkg::OP_REVERSE_BYTES_IN_ELEM, vpr_pkg::OP_REVERSE_HALVES_IN_ELEM,
			vpr_pkg::OP_REVERSE_WORDS_IN_ELEM: begin
				// Word reversal is identity at this element width
				if (lnk.reqOp == vpr_pkg::OP_REVERSE_HALVES_IN_ELEM) unitB = vpr_pkg::UNIT_HALF;
				if (lnk.reqOp == vpr_pkg::OP_REVERSE_WORDS_IN_ELEM) unitB = vpr_pkg::UNIT_WORD;
				for (int i = 0; i < NE; i++) begin
					for (int k = 0; k < PB; k++) begin
						sel = (PB/unitB - 1 - k/unitB) * unitB + k % unitB;
						rVec[i*EW + sel*BW +: BW] = srcA[i*EW + k*BW +: BW];
					end
				end
			end
			vpr_pkg::OP_INTERLEAVE_EVEN, vpr_pkg::OP_INTERLEAVE_ODD: begin
				sel = (lnk.reqOp == vpr_pkg::OP_INTERLEAVE_ODD) ? 1 : 0;
				for (int i = 0; i < NE/2; i++) begin
					rVec[2*i*EW +: EW] = srcA[(2*i+sel)*EW +: EW];
					rVec[(2*i+1)*EW +: EW] = srcB[(2*i+sel)*EW +: EW];
				end
			end
			vpr_pkg::OP_CONCAT_EVEN, vpr_pkg::OP_CONCAT_ODD: begin
				sel = (lnk.reqOp == vpr_pkg::OP_CONCAT_ODD) ? 1 : 0;
				for (int i = 0; i < NE; i++) begin
					rVec[i*EW +: EW] = (i < NE/2) ? srcA[(2*i+sel)*EW +: EW] : srcB[(2*i+sel-NE)*EW +: EW];
				end
			end
			vpr_pkg::OP_INTERLEAVE_LOW_HALVES, vpr_pkg::OP_INTERLEAVE_HIGH_HALVES: begin
				half = (lnk.reqOp == vpr_pkg::OP_INTERLEAVE_HIGH_HALVES) ? NE/2 : 0;
				for (int i = 0; i < NE/2; i++) begin
					rVec[2*i*EW +: EW] = srcA[(i+half)*EW +: EW];
					rVec[(2*i+1)*EW +: EW] = srcB[(i+half)*EW +: EW];
				end
			end
			vpr_pkg::OP_PAIR_WINDOW_EXTRACT: begin
				for (int i = 0; i < NE; i++) begin
					sel = i + int'(lnk.elemIdx);
					rVec[i*EW +: EW] = (sel < NE) ? srcA[sel*EW +: EW] : srcB[(sel-NE)*EW +: EW];
				end
			end
			vpr_pkg::OP_SHIFT_INSERT_SCALAR: rVec = {srcA[VW-EW-1:0], lnk.scalar};
			vpr_pkg::OP_BROADCAST_ELEMENT: rVec = {NE{srcA[lnk.elemIdx*EW +: EW]}};
			vpr_pkg::OP_SIGNED_WIDEN_LOW, vpr_pkg::OP_SIGNED_WIDEN_HIGH,
			vpr_pkg::OP_ZERO_WIDEN_LOW, vpr_pkg::OP_ZERO_WIDEN_HIGH: begin
				isWiden = 1'b1;
				half = (lnk.reqOp == vpr_pkg::OP_SIGNED_WIDEN_HIGH ||
					lnk.reqOp == vpr_pkg::OP_ZERO_WIDEN_HIGH) ? NE/2 : 0;
				for (int j = 0; j < NE/2; j++) begin
					pickEl = srcA[(j+half)*EW +: EW];
					if (lnk.reqOp == vpr_pkg::OP_SIGNED_WIDEN_LOW || lnk.reqOp == vpr_pkg::OP_SIGNED_WIDEN_HIGH)
						rVec[j*2*EW +: 2*EW] = {{EW{pickEl[EW-1]}}, pickEl};
					else
						rVec[j*2*EW +: 2*EW] = {{EW{1'b0}}, pickEl};
				end
			end
			vpr_pkg::OP_INDEX_GEN: begin
				for (int i = 0; i < NE; i++) rVec[i*EW +: EW] = lnk.idxStart + EW'(i) * lnk.idxStep;
			end
			vpr_pkg::OP_MOVE_PREFIX: begin
				for (int i = 0; i < NE; i++)
					rVec[i*EW +: EW] = (!lnk.reqPredicated || lnk.govPred[i*PB]) ? srcA[i*EW +: EW] : srcB[i*EW +: EW];
			end
			vpr_pkg::OP_FP_ORDERED_SUM: begin
				rScalar = lnk.scalar;
				for (int i = 0; i < NE; i++)
					if (lnk.govPred[i*PB]) rScalar = fpAdd(rScalar, srcA[i*EW +: EW]);
			end
			default: begin
				for (int i = 0; i < NE; i++)
					tree[i] = lnk.govPred[i*PB] ? srcA[i*EW +: EW] : fillVal(lnk.reqOp);
				for (int s = 1; s < NE; s = s * 2) begin
					for (int i = 0; i < NE; i = i + 2 * s)
						tree[i] = combine(lnk.reqOp, tree[i], tree[i+s]);
				end
				rScalar = tree[0];
			end
		endcase
		for (int i = 0; i < NE; i++) begin
			if (isWiden && i < NE/2) rPred[i*2*PB +: 2*PB] = rVec[i*2*EW +: 2*PB];
			else if (!isWiden) rPred[i*PB +: PB] = rVec[i*EW +: PB];
		end
	end

	// A bad prefix pairing is dropped and reported as undefined
	always_ff @(posedge core_clk) begin
		if (rst) begin
			lnk.resValid <= 1'b0;
			lnk.resUndef <= 1'b0;
		end else begin
			lnk.resValid <= lnk.reqValid && !lnk.reqPairBad;
			lnk.resUndef <= lnk.reqValid && lnk.reqPairBad;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			lnk.resVec <= '0;
			lnk.resPred <= '0;
			lnk.resScalar <= '0;
			activeCount <= '0;
		end else if (lnk.reqValid && !lnk.reqPairBad) begin
			lnk.resVec <= rVec;
			lnk.resPred <= rPred;
			lnk.resScalar <= rScalar;
			activeCount <= actCnt;
		end
	end
endmodule

/* hdl/vpr_issue.sv */
// Issue end: registers operations onto the link and checks prefix pairing.
// Assumes the user side presents decoded fields on core_clk.
`timescale 1ns/1ns
module vpr_issue (
	input wire logic core_clk,
	input wire logic rst,
	vpr_link_if.iss lnk,
	input wire logic usrValid,
	input wire vpr_pkg::vpr_cls_t usrClass,
	input wire vpr_pkg::vpr_op_t usrOp,
	input wire logic usrPredMode,
	input wire logic usrPredicated,
	input wire logic usrWideForm,
	input wire logic [vpr_pkg::PRW-1:0] usrGovReg,
	input wire logic [vpr_pkg::SW-1:0] usrSize,
	input wire logic [vpr_pkg::RW-1:0] usrDst,
	input wire logic [vpr_pkg::RW-1:0] usrSrc1,
	input wire logic [vpr_pkg::RW-1:0] usrSrc2,
	input wire logic [vpr_pkg::SRC_N-1:0] usrSrcUsed,
	input wire logic [vpr_pkg::VW-1:0] usrVecA,
	input wire logic [vpr_pkg::VW-1:0] usrVecB,
	input wire logic [vpr_pkg::PW-1:0] usrGovPred,
	input wire logic [vpr_pkg::PW-1:0] usrPredA,
	input wire logic [vpr_pkg::PW-1:0] usrPredB,
	input wire logic [vpr_pkg::EW-1:0] usrScalar,
	input wire logic [vpr_pkg::EW-1:0] usrStart,
	input wire logic [vpr_pkg::EW-1:0] usrStep,
	input wire logic [vpr_pkg::IW-1:0] usrElemIdx,
	output logic prefixPending,
	output logic pairViolation
);
	logic pfxPredicated_reg;
	logic [vpr_pkg::PRW-1:0] pfxGov_reg;
	logic [vpr_pkg::SW-1:0] pfxSize_reg;
	logic [vpr_pkg::RW-1:0] pfxDst_reg;
	logic pairOk;
	logic isCapable;
	logic toDatapath;

	assign isCapable = usrClass == vpr_pkg::CLS_PREFIX_CAPABLE;
	// Halt and breakpoint carry no datapath work
	assign toDatapath = usrClass != vpr_pkg::CLS_HALT && usrClass != vpr_pkg::CLS_BREAKPOINT;

	always_comb begin
		pairOk = isCapable || !toDatapath;
		if (isCapable) begin
			if (usrDst != pfxDst_reg) pairOk = 1'b0;
			if (usrSrcUsed[0] && usrSrc1 == pfxDst_reg) pairOk = 1'b0;
			if (usrSrcUsed[1] && usrSrc2 == pfxDst_reg) pairOk = 1'b0;
			if (pfxPredicated_reg) begin
				if (!usrPredicated) pairOk = 1'b0;
				if (usrGovReg != pfxGov_reg) pairOk = 1'b0;
				if (usrSize != pfxSize_reg && !usrWideForm) pairOk = 1'b0;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			prefixPending <= 1'b0;
			pfxPredicated_reg <= 1'b0;
			pfxGov_reg <= '0;
			pfxSize_reg <= '0;
			pfxDst_reg <= '0;
		end else if (usrValid) begin
			prefixPending <= usrClass == vpr_pkg::CLS_MOVE_PREFIX;
			if (usrClass == vpr_pkg::CLS_MOVE_PREFIX) begin
				pfxPredicated_reg <= usrPredicated;
				pfxGov_reg <= usrGovReg;
				pfxSize_reg <= usrSize;
				pfxDst_reg <= usrDst;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			lnk.reqValid <= 1'b0;
			lnk.reqPairBad <= 1'b0;
			pairViolation <= 1'b0;
		end else begin
			lnk.reqValid <= usrValid && toDatapath;
			lnk.reqPairBad <= usrValid && prefixPending && !pairOk;
			pairViolation <= usrValid && prefixPending && !pairOk;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			lnk.reqOp <= vpr_pkg::OP_MOVE_PREFIX;
			lnk.reqPredMode <= 1'b0;
			lnk.reqPredicated <= 1'b0;
			lnk.vecA <= '0;
			lnk.vecB <= '0;
			lnk.govPred <= '0;
			lnk.predA <= '0;
			lnk.predB <= '0;
			lnk.scalar <= '0;
			lnk.idxStart <= '0;
			lnk.idxStep <= '0;
			lnk.elemIdx <= '0;
		end else if (usrValid) begin
			lnk.reqOp <= (usrClass == vpr_pkg::CLS_MOVE_PREFIX) ? vpr_pkg::OP_MOVE_PREFIX : usrOp;
			lnk.reqPredMode <= usrPredMode;
			lnk.reqPredicated <= usrPredicated;
			lnk.vecA <= usrVecA;
			lnk.vecB <= usrVecB;
			lnk.govPred <= usrGovPred;
			lnk.predA <= usrPredA;
			lnk.predB <= usrPredB;
			lnk.scalar <= usrScalar;
			lnk.idxStart <= usrStart;
			lnk.idxStep <= usrStep;
			lnk.elemIdx <= usrElemIdx;
		end
	end
endmodule

/* tb/vpr_link_properties.sv */
// Link checks between the issue end and the permute/reduce datapath.
// Assumes one core clock and the synchronous active-high reset.
`timescale 1ns/1ns
module vpr_link_properties (
	input logic core_clk,
	input logic rst,
	input logic reqValid,
	input vpr_pkg::vpr_op_t reqOp,
	input logic reqPredMode,
	input logic reqPairBad,
	input logic [vpr_pkg::VW-1:0] vecA,
	input logic [vpr_pkg::PW-1:0] govPred,
	input logic [vpr_pkg::IW-1:0] elemIdx,
	input logic resValid,
	input logic resUndef,
	input logic [vpr_pkg::VW-1:0] resVec,
	input logic [vpr_pkg::EW-1:0] resScalar
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	sequence s_good;
		reqValid && !reqPairBad && !reqPredMode;
	endsequence
	// No lane active, so only the fill value can reach the result
	sequence s_empty(vpr_pkg::vpr_op_t op);
		s_good ##0 (reqOp == op && govPred == '0);
	endsequence
	property p_bcast;
		logic [vpr_pkg::EW-1:0] v;
		(s_good ##0 (reqOp == vpr_pkg::OP_BROADCAST_ELEMENT, v = vecA[elemIdx*vpr_pkg::EW+:vpr_pkg::EW]))
			|=> resVec == {vpr_pkg::NE{v}};
	endproperty
	a_good_pair_answered: assert property (reqValid && !reqPairBad |=> resValid && !resUndef)
		else $error("good request without result");
	a_bad_pair_dropped: assert property (reqValid && reqPairBad |=> resUndef && !resValid)
		else $error("bad pairing not dropped");
	a_no_stray_result: assert property (!reqValid |=> !resValid && !resUndef)
		else $error("result without request");
	a_undef_keeps_data: assert property (resUndef |-> $stable(resVec) && $stable(resScalar))
		else $error("dropped op changed results");
	a_pack_zero_fill: assert property (s_empty(vpr_pkg::OP_ACTIVE_PACK) |=> resVec == '0)
		else $error("pack did not zero fill");
	a_bcast_all_lanes: assert property (p_bcast)
		else $error("broadcast lane mismatch");
	a_and_fill: assert property (s_empty(vpr_pkg::OP_AND_REDUCE) |=> resScalar == vpr_pkg::INT_ONES)
		else $error("and fill wrong");
	a_smax_fill: assert property (s_empty(vpr_pkg::OP_SIGNED_MAX_REDUCE) |=> resScalar == vpr_pkg::INT_SMIN)
		else $error("signed max fill wrong");
	a_umin_fill: assert property (s_empty(vpr_pkg::OP_UNSIGNED_MIN_REDUCE) |=> resScalar == vpr_pkg::INT_ONES)
		else $error("unsigned min fill wrong");
	a_fpmax_fill: assert property (s_empty(vpr_pkg::OP_FP_TREE_MAX) |=> resScalar == vpr_pkg::FP_NEG_INF)
		else $error("fp max fill wrong");
endmodule

/* tb/vector_permute_reduce_unit_tb_top.sv */
// Bench: issue end and datapath joined by the link, driven from the user side, checked at the link results and pairViolation.
// Assumes package, link interface and both design ends compile first.
`timescale 1ns/1ns
module vector_permute_reduce_unit_tb_top;
	typedef struct {logic u; logic [1:0] s; logic [255:0] v;} vpr_exp_t;
	vpr_exp_t expQ[$];
	vpr_exp_t e;
	logic core_clk = 1'h0, rst = 1'h1, usrValid = 1'h0, usrPredMode = 1'h0, usrPredicated = 1'h0, usrWideForm = 1'h0;
	vpr_pkg::vpr_cls_t usrClass = vpr_pkg::CLS_OTHER;
	vpr_pkg::vpr_op_t usrOp = vpr_pkg::OP_REVERSE_ELEMENTS;
	logic [3:0] usrGovReg = 4'h0;
	logic [1:0] usrSize = 2'h0;
	logic [4:0] usrSrc1 = 5'h09;
	logic [255:0] usrVecA = '0, usrVecB = '0;
	logic [31:0] usrGovPred = '0, usrPredA = '0, usrPredB = '0, usrScalar = '0, usrStart = '0, usrStep = '0, q;
	logic [2:0] usrElemIdx = 3'h0;
	logic pv, pvD;
	wire [255:0] a = usrVecA, b = usrVecB;
	wire [31:0] g = usrGovPred, sc = usrScalar;
	int numErrors = 0, totalChecks = 0;
	vpr_link_if lnk();
	vpr_issue i_vpr_issue (.core_clk, .rst, .lnk, .usrValid, .usrClass, .usrOp, .usrPredMode, .usrPredicated,
		.usrWideForm, .usrGovReg, .usrSize, .usrDst(usrGovReg[3] ? 5'h02 : 5'h01), .usrSrc1, .usrSrc2(5'h0a),
		.usrSrcUsed(2'h3), .usrVecA, .usrVecB, .usrGovPred, .usrPredA, .usrPredB, .usrScalar, .usrStart, .usrStep,
		.usrElemIdx, .prefixPending(), .pairViolation(pv));
	vpr_unit i_vpr_unit (.core_clk, .rst, .lnk, .activeCount());
	vpr_link_properties i_vpr_link_properties (.core_clk, .rst, .reqValid(lnk.reqValid), .reqOp(lnk.reqOp),
		.reqPredMode(lnk.reqPredMode), .reqPairBad(lnk.reqPairBad), .vecA(lnk.vecA), .govPred(lnk.govPred),
		.elemIdx(lnk.elemIdx), .resValid(lnk.resValid), .resUndef(lnk.resUndef), .resVec(lnk.resVec),
		.resScalar(lnk.resScalar));
	always #4 core_clk = ~core_clk;
	function automatic logic [31:0] el(logic [255:0] v, int i);
		return v[i*32+:32];
	endfunction
	function automatic logic [255:0] expv(logic [5:0] op);
		logic [255:0] r;
		logic [31:0] x;
		int n, h;
		r = '0;
		n = 0;
		h = op[0] ? 0 : 4;
		for (int i = 0; i < 8; i++) begin
			x = el(a, i);
			case (op)
				6'h04: if (g[i*4]) begin
					r[n*32+:32] = x;
					n++;
				end
				6'h05: r[i*32+:32] = el(b, i) < 8 ? el(a, el(b, i)) : '0;
				6'h06: r[i*32+:32] = el(a, 7 - i);
				6'h07: r[i*32+:32] = {x[7:0], x[15:8], x[23:16], x[31:24]};
				6'h08: r[i*32+:32] = {x[15:0], x[31:16]};
				6'h09: r[i*32+:32] = x;
				6'h0a: r[i*32+:32] = i[0] ? el(b, i - 1) : x;
				6'h0b: r[i*32+:32] = i[0] ? el(b, i) : el(a, i + 1);
				6'h0c: r[i*32+:32] = i < 4 ? el(a, 2 * i) : el(b, 2 * i - 8);
				6'h0d: r[i*32+:32] = i < 4 ? el(a, 2 * i + 1) : el(b, 2 * i - 7);
				6'h0e: r[i*32+:32] = i[0] ? el(b, i / 2) : el(a, i / 2);
				6'h0f: r[i*32+:32] = i[0] ? el(b, 4 + i / 2) : el(a, 4 + i / 2);
				6'h10: r[i*32+:32] = i + usrElemIdx < 8 ? el(a, i + usrElemIdx) : el(b, i + usrElemIdx - 8);
				6'h11: r[i*32+:32] = i == 0 ? sc : el(a, i - 1);
				6'h12: r[i*32+:32] = el(a, usrElemIdx);
				6'h17: r[i*32+:32] = usrStart + usrStep * i;
				default: if (i < 4) r[i*64+:64] = {{32{op < 6'h15 && a[(i+h)*32+31]}}, el(a, i + h)};
			endcase
		end
		return r;
	endfunction
	function automatic logic [31:0] exps(logic [5:0] op);
		logic [31:0] r, x;
		int l;
		logic any;
		l = 7;
		any = 1'h0;
		case (op)
			6'h20: r = sc;
			6'h21: r = vpr_pkg::FP_POS_ZERO;
			6'h22: r = vpr_pkg::FP_NEG_INF;
			6'h23: r = vpr_pkg::FP_POS_INF;
			6'h24, 6'h25: r = vpr_pkg::FP_DEF_NAN;
			6'h26, 6'h2e: r = vpr_pkg::INT_ONES;
			6'h2b: r = vpr_pkg::INT_SMIN;
			6'h2c: r = vpr_pkg::INT_SMAX;
			default: r = vpr_pkg::INT_ZERO;
		endcase
		for (int i = 0; i < 8; i++) if (g[i*4]) begin
			x = el(a, i);
			l = i;
			any = 1'h1;
			case (op)
				6'h26: r &= x;
				6'h27: r ^= x;
				6'h28: r |= x;
				6'h29, 6'h2a: r += x;
				6'h2b: if ($signed(x) > $signed(r)) r = x;
				6'h2c: if ($signed(x) < $signed(r)) r = x;
				6'h2d: if (x > r) r = x;
				6'h2e: if (x < r) r = x;
				default: ;
			endcase
		end
		if (op < 6'h04) r = op[0] ? el(a, l) : el(a, (l + 1) % 8);
		if (op < 6'h02 && !any) r = sc;
		return r;
	endfunction
	// Halt and breakpoint never reach the link, so they leave no note
	task automatic send(logic [5:0] op, logic [2:0] c, logic u, logic [1:0] s, logic [255:0] v);
		usrValid <= 1'h1;
		usrOp <= vpr_pkg::vpr_op_t'(op);
		usrClass <= vpr_pkg::vpr_cls_t'(c);
		if (c != 3'h2 && c != 3'h3) expQ.push_back('{u, s, v});
		@(posedge core_clk);
	endtask
	task automatic pair(logic pp, logic [2:0] c, logic fp, logic [3:0] gv, logic [1:0] zs, logic wd, logic [4:0] s,
		logic u);
		usrPredicated <= pp;
		usrGovReg <= 4'h1;
		usrSize <= 2'h2;
		usrWideForm <= 1'h0;
		usrSrc1 <= 5'h09;
		send(6'h18, 3'h4, 1'h0, 2'h2, '0);
		usrPredicated <= fp;
		usrGovReg <= gv;
		usrSize <= zs;
		usrWideForm <= wd;
		usrSrc1 <= s;
		send(6'h06, c, u, 2'h0, expv(6'h06));
	endtask
	task automatic chk(logic [255:0] seen, logic [255:0] exp);
		totalChecks++;
		if (seen !== exp) begin
			numErrors++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic close_out;
		$display("Checks %0d, errors %0d", totalChecks, numErrors);
		if (numErrors == 0 && totalChecks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	always @(posedge core_clk) begin
		pvD <= pv;
		if (lnk.resValid === 1'h1 || lnk.resUndef === 1'h1) begin
			if (expQ.size() == 0) chk(1'h1, 1'h0);
			else begin
				e = expQ.pop_front();
				chk({pvD, lnk.resUndef}, {2{e.u}});
				if (!e.u && e.s == 2'h0) chk(lnk.resVec, e.v);
				if (!e.u && e.s == 2'h1) chk(lnk.resScalar, e.v);
				if (!e.u && e.s == 2'h3) chk(lnk.resPred, e.v);
			end
		end
	end
	initial begin
		void'($urandom(19));
		repeat (3) @(posedge core_clk);
		rst <= 1'h0;
		// Second pass: all lanes inactive, and a reversing index table
		for (int p = 0; p < 2; p++) begin
			for (int i = 0; i < 8; i++) begin
				usrVecA[i*32+:32] <= p ? 32'(7 - i) : $urandom;
				usrVecB[i*32+:32] <= p ? 32'(7 - i) : $urandom;
			end
			usrGovPred <= p ? '0 : $urandom;
			usrPredA <= $urandom;
			usrPredB <= $urandom;
			usrScalar <= $urandom;
			usrStart <= $urandom;
			usrStep <= $urandom;
			usrElemIdx <= 3'($urandom);
			@(posedge core_clk);
			for (int k = 4; k < 24; k++) send(6'(k), 3'h0, 1'h0, 2'h0, expv(6'(k)));
			for (int k = 0; k < 47; k++)
				if (k < 4 || k > 37 || (k > 31 && g == '0)) send(6'(k), 3'h0, 1'h0, 2'h1, 256'(exps(6'(k))));
			usrPredMode <= 1'h1;
			for (int i = 0; i < 8; i++) q[i*4+:4] = usrPredA[28-i*4+:4];
			send(6'h06, 3'h0, 1'h0, 2'h3, 256'(q));
			usrPredMode <= 1'h0;
			usrValid <= 1'h0;
			@(posedge core_clk);
		end
		pair(0, 1, 0, 0, 0, 0, 9, 0);
		pair(0, 1, 1, 3, 1, 0, 9, 0);
		pair(1, 1, 0, 1, 2, 0, 9, 1);
		pair(0, 0, 0, 0, 0, 0, 9, 1);
		pair(0, 2, 0, 0, 0, 0, 9, 0);
		pair(0, 3, 0, 0, 0, 0, 9, 0);
		pair(0, 1, 0, 0, 0, 0, 1, 1);
		pair(0, 1, 1, 8, 1, 0, 9, 1);
		pair(1, 1, 1, 2, 2, 0, 9, 1);
		pair(1, 1, 1, 1, 3, 0, 9, 1);
		pair(1, 1, 1, 1, 3, 1, 9, 0);
		pair(1, 1, 1, 1, 2, 0, 9, 0);
		usrValid <= 1'h0;
		repeat (4) @(posedge core_clk);
		chk(expQ.size(), 0);
		close_out;
	end
	initial begin
		repeat (2000) @(posedge core_clk);
		numErrors++;
		close_out;
	end
endmodule
